// *** hdl/step_seq_pkg.sv ***
/*
  Shared constants for the step and direction microstep sequencer.
  Assumes a single 100 MHz core clock and a synchronous active high reset.
*/
package step_seq_pkg;
  // Clock and table geometry
  localparam int          CLK_MHZ          = 100;
  localparam int          TABLE_BITS       = 10;
  localparam int          TABLE_SIZE       = 1024;
  // Standstill timeouts in clock cycles
  localparam int          STANDSTILL_LOG   = 20;
  localparam int          FAST_STILL_LOG   = 18;
  localparam int          STANDSTILL_COUNT = 1 << STANDSTILL_LOG;
  localparam int          FAST_STILL_COUNT = 1 << FAST_STILL_LOG;
  // Resolution codes: 0 is 256 microsteps per full step, 8 is full step
  localparam int          RES_BITS         = 4;
  localparam logic [3:0]  RES_FULL         = 4'h8;
  localparam logic [3:0]  RES_RESET        = 4'h0;
  // Interpolation always runs at the finest table resolution
  localparam int          INTERP_PARTS     = 256;
  // Current setting width and reset values
  localparam int          CUR_BITS         = 5;
  localparam logic [4:0]  HOLD_RESET       = 5'h08;
  localparam logic [4:0]  RUN_RESET        = 5'h1F;
  // Register indices
  localparam logic [3:0]  ADDR_GLOBAL_CFG  = 4'h0;
  localparam logic [3:0]  ADDR_CHOP_CFG    = 4'h1;
  localparam logic [3:0]  ADDR_COIL_CUR    = 4'h2;
  localparam logic [3:0]  ADDR_STATUS      = 4'h3;
  // Field positions
  localparam int          GCFG_FAST_POS    = 0;
  localparam int          CHOP_RES_POS     = 0;
  localparam int          CHOP_INTPOL_POS  = 4;
  localparam int          CHOP_DEDGE_POS   = 5;
  localparam int          CUR_HOLD_POS     = 0;
  localparam int          CUR_RUN_POS      = 8;
  localparam int          STAT_CNT_POS     = 0;
  localparam int          STAT_STILL_POS   = 16;

  // Step width for a resolution code, clamped at full step
  function automatic logic [9:0] step_width(input logic [3:0] res);
    logic [3:0] r;
    r = (res > RES_FULL) ? RES_FULL : res;
    return 10'(10'h001 << r);
  endfunction

  // Nearest valid position: clear low bits, set half step offset
  function automatic logic [9:0] snap_pos(input logic [9:0] pos,
                                          input logic [3:0] res);
    logic [9:0] w;
    w = step_width(res);
    if (w == 10'h001)
      return pos;
    return (pos & ~(w - 10'h001)) | (w >> 1);
  endfunction
endpackage

// *** hdl/pin_sync.sv ***
/*
  Two flip-flop synchroniser for one asynchronous pin.
  Assumes nothing reads the first stage except the second.
*/
module pin_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      pinSync
);
  logic stage1;   // Metastable stage, read only by stage 2
  logic next_s1;
  logic next_s2;

  // Next values
  always_comb begin
    next_s1 = pinIn;
    next_s2 = stage1;
  end

  // Register both stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1  <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      stage1  <= next_s1;
      pinSync <= next_s2;
    end
  end
endmodule

// *** hdl/step_timer.sv ***
/*
  Step interval timer with standstill detection.
  Assumes stepEvent is a one-cycle pulse on core_clk.
*/
module step_timer
  import step_seq_pkg::*;
#(
  parameter int STILL_CYCLES = STANDSTILL_COUNT,
  parameter int FAST_CYCLES  = FAST_STILL_COUNT
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        stepEvent,
  input  wire logic        fastStill,
  output logic [20:0]      interval,
  output logic             stillReached
);
  // Timeouts must fit the 21-bit timer, fast never above normal
  if (FAST_CYCLES < 2 || STILL_CYCLES < FAST_CYCLES ||
      STILL_CYCLES > (1 << 21) - 1) begin : g_badTimeout
    $error("step_timer: bad timeout parameters");
  end

  logic [20:0] count;        // Cycles since the last active step
  logic [20:0] next_count;
  logic [20:0] next_interval;
  logic [20:0] limit;

  // Timer restarts on each step, saturates at timeout
  always_comb begin
    limit         = fastStill ? 21'(FAST_CYCLES) : 21'(STILL_CYCLES);
    next_count    = count;
    next_interval = interval;
    if (stepEvent) begin
      next_count    = 21'h000000;
      next_interval = (count >= limit) ? limit : count + 21'h1;
    end else if (count < limit) begin
      next_count = count + 21'h000001;
    end
  end

  // Register timer state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count    <= 21'h000000;
      interval <= 21'h000000;
    end else begin
      count    <= next_count;
      interval <= next_interval;
    end
  end

  // Timeout reached; fast setting shortens it
  assign stillReached = (count >= limit);
endmodule

// *** hdl/step_dir_microstep_sequencer.sv ***
/*
  Step and direction front end with microstep counter, interpolator,
  standstill detection and hold/run current selection.
  Assumes asynchronous stepPin and dirPin from an external controller
  and a simple register port on core_clk.
*/
// The address map and the strobed register port were left to the implementer.
module step_dir_microstep_sequencer
  import step_seq_pkg::*;
#(
  parameter int STILL_CYCLES = STANDSTILL_COUNT,
  parameter int FAST_CYCLES  = FAST_STILL_COUNT
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        stepPin,
  input  wire logic        dirPin,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  output logic      [9:0]  microCount,
  output logic             standstill,
  output logic      [4:0]  coilCurrent,
  output logic             microStepPulse
);
  // Pin levels after the two-stage synchronisers. The chain costs two
  // cycles of latency and the edge detect one more, so an active edge
  // acts three clocks after it reaches the pin. That latency is the
  // price of never letting a metastable level reach the counter.
  // Sync outputs
  logic        stepSync;
  logic        dirSync;
  logic        stepPrev;         // Previous synchronised step level
  logic        next_stepPrev;

  // Configuration registers
  logic        fastStill;        // Global config bit
  logic [3:0]  resolution;       // Chopper config resolution code
  logic        intpolEn;         // Chopper config interpolation enable
  logic        dedge;            // Chopper config double-edge enable
  logic [4:0]  holdCurrent;      // hold_current_setting
  logic [4:0]  runCurrent;       // run_current_setting
  logic        next_fastStill;
  logic [3:0]  next_resolution;
  logic        intpolNext;
  logic        dedgeNext;
  logic [4:0]  next_holdCurrent;
  logic [4:0]  next_runCurrent;
  logic [31:0] next_regRdata;

  // Sequencer state
  logic [9:0]  next_microCount;
  logic        next_standstill;
  logic [4:0]  next_coilCurrent;
  logic        next_microStepPulse;
  logic        stepEvent;        // Active edge this cycle
  logic [20:0] interval;         // Last measured step period
  logic        stillReached;

  // Interpolator state. A burst issues one microstep at once and the
  // rest spaced by the previous step interval divided by the width.
  // A new step at a code other than 0 aborts a running burst, so unissued microsteps
  // are lost; with a rising step rate the motor angle may jump a bit.
  // The division is a shift by the resolution code, which is exact
  // because every width is a power of two.
  typedef enum logic [1:0] {
    IP_IDLE = 2'b00,
    IP_RUN  = 2'b01
  } ip_state_t;
  ip_state_t   ipState;
  ip_state_t   next_ipState;
  logic [8:0]  ipLeft;           // Microsteps still to issue
  logic [8:0]  next_ipLeft;
  logic [20:0] ipTimer;          // Cycles to the next microstep
  logic [20:0] next_ipTimer;
  logic [20:0] ipPeriod;         // Cycles between microsteps
  logic [20:0] next_ipPeriod;
  logic        ipDir;            // Direction held for this burst
  logic        next_ipDir;
  logic [9:0]  width;            // Table positions per input step
  logic [9:0]  widthParts;       // Microsteps per interpolated step
  logic [3:0]  resClamp;         // Resolution code clamped at full step

  // Pin synchronisers, nothing reads the pins directly
  pin_sync u_stepSync (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    (stepPin),
    .pinSync  (stepSync)
  );
  pin_sync u_dirSync (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    (dirPin),
    .pinSync  (dirSync)
  );

  // Standstill and interval timer
  step_timer #(
    .STILL_CYCLES (STILL_CYCLES),
    .FAST_CYCLES  (FAST_CYCLES)
  ) u_timer (
    .core_clk     (core_clk),
    .rst          (rst),
    .stepEvent    (stepEvent),
    .fastStill    (fastStill),
    .interval     (interval),
    .stillReached (stillReached)
  );

  // Edge detect on the synchronised step level. stepPrev resets low to
  // match the idle pin level, so no false edge follows reset. Enabling
  // double-edge mode while the pin is high is harmless: stepPrev
  // already equals the level and only a real change counts.
  always_comb begin
    next_stepPrev = stepSync;
    if (dedge)
      stepEvent = stepSync ^ stepPrev;
    else
      stepEvent = stepSync & ~stepPrev;
  end

  // Register port: writes and one-cycle-late read data.
  // Software never waits: a write takes effect at the next edge and
  // read data stand for exactly one cycle, zero otherwise. Unmapped
  // indices are ignored on write and read back as zero.
  always_comb begin
    next_fastStill   = fastStill;
    next_resolution  = resolution;
    intpolNext       = intpolEn;
    dedgeNext        = dedge;
    next_holdCurrent = holdCurrent;
    next_runCurrent  = runCurrent;
    next_regRdata    = 32'h00000000;
    if (regWrite) begin
      case (regAddr)
        ADDR_GLOBAL_CFG: next_fastStill = regWdata[GCFG_FAST_POS];
        ADDR_CHOP_CFG: begin
          next_resolution = regWdata[CHOP_RES_POS +: RES_BITS];
          intpolNext      = regWdata[CHOP_INTPOL_POS];
          dedgeNext       = regWdata[CHOP_DEDGE_POS];
        end
        // Only the current settings stay in the motion register set
        ADDR_COIL_CUR: begin
          next_holdCurrent = regWdata[CUR_HOLD_POS +: CUR_BITS];
          next_runCurrent  = regWdata[CUR_RUN_POS +: CUR_BITS];
        end
        default: ;                                           // Ignored
      endcase
    end
    if (regRead) begin
      case (regAddr)
        ADDR_GLOBAL_CFG: next_regRdata[GCFG_FAST_POS] = fastStill;
        ADDR_CHOP_CFG: begin
          next_regRdata[CHOP_RES_POS +: RES_BITS] = resolution;
          next_regRdata[CHOP_INTPOL_POS]          = intpolEn;
          next_regRdata[CHOP_DEDGE_POS]           = dedge;
        end
        ADDR_COIL_CUR: begin
          next_regRdata[CUR_HOLD_POS +: CUR_BITS] = holdCurrent;
          next_regRdata[CUR_RUN_POS +: CUR_BITS]  = runCurrent;
        end
        ADDR_STATUS: begin
          next_regRdata[STAT_CNT_POS +: TABLE_BITS] = microCount;
          next_regRdata[STAT_STILL_POS]             = standstill;
        end
        default: next_regRdata = 32'h00000000;               // Unmapped
      endcase
    end
  end

  // Step width and microstep period from the last interval.
  // Codes above full step behave as full step in width, snap and
  // the interpolator's period shift, so a stray code cannot shrink
  // the microstep spacing far below the measured interval over the width.
  always_comb begin
    resClamp   = (resolution > RES_FULL) ? RES_FULL : resolution;
    width      = step_width(resolution);
    widthParts = width;
  end

  // Microstep counter, interpolator and standstill.
  // Priority: a coarsening resolution write first, then a step event,
  // then the running burst. A step landing in the same cycle as a
  // coarsening write is dropped; the snap matters more for symmetry
  // between the two directions than one lost microstep.
  // The standstill flag clears on any active step not dropped by a coarsening write, even one that
  // arrives exactly at the timeout, since the timer restarts then.
  always_comb begin
    next_microCount     = microCount;
    next_ipState        = ipState;
    next_ipLeft         = ipLeft;
    next_ipTimer        = ipTimer;
    next_ipPeriod       = ipPeriod;
    next_ipDir          = ipDir;
    next_microStepPulse = 1'b0;
    next_standstill     = standstill;
    // Snap to nearest valid position when resolution coarsens
    if (regWrite && regAddr == ADDR_CHOP_CFG &&
        regWdata[CHOP_RES_POS +: RES_BITS] > resolution) begin
      next_microCount = snap_pos(microCount,
                                 regWdata[CHOP_RES_POS +: RES_BITS]);
      next_ipState    = IP_IDLE;
    end else if (stepEvent) begin
      next_standstill = 1'b0;
      if (intpolEn && width != 10'h001) begin
        // Skip what the old burst left, start a new one
        next_ipState  = IP_RUN;
        next_ipLeft   = 9'(widthParts - 10'h001);
        next_ipDir    = dirSync;
        // Spread the previous period over width parts, at least 1
        next_ipPeriod = (interval >> resClamp) == 21'h0 ?
                        21'h000001 : (interval >> resClamp);
        next_ipTimer  = next_ipPeriod;
        next_microCount = dirSync ? microCount - 10'h001
                                  : microCount + 10'h001;
        next_microStepPulse = 1'b1;
      end else begin
        // Wraps modulo table size in either direction
        next_microCount = dirSync ? microCount - width
                                  : microCount + width;
        next_microStepPulse = 1'b1;
      end
    end else begin
      if (stillReached)
        next_standstill = 1'b1;
      case (ipState)
        IP_RUN: begin
          if (!intpolEn) begin
            next_ipState = IP_IDLE;
          end else if (ipTimer <= 21'h000001) begin
            next_microCount = ipDir ? microCount - 10'h001
                                    : microCount + 10'h001;
            next_microStepPulse = 1'b1;
            next_ipTimer = ipPeriod;
            next_ipLeft  = ipLeft - 9'h001;
            if (ipLeft == 9'h001)
              next_ipState = IP_IDLE;
          end else begin
            next_ipTimer = ipTimer - 21'h000001;
          end
        end
        IP_IDLE: next_ipState = IP_IDLE;
        default: next_ipState = IP_IDLE;
      endcase
    end
    // Hold current while standing still
    next_coilCurrent = next_standstill ? holdCurrent
                                       : runCurrent;
  end

  // Register all state. Every output of this module comes straight
  // from one of these flip-flops; the interpolator period resets to
  // one, and a burst that starts before any interval was measured
  // takes a period of one from the clamp rather than a zero count.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stepPrev       <= 1'b0;
      fastStill      <= 1'b0;
      resolution     <= RES_RESET;
      intpolEn       <= 1'b0;
      dedge          <= 1'b0;
      holdCurrent    <= HOLD_RESET;
      runCurrent     <= RUN_RESET;
      regRdata       <= 32'h00000000;
      microCount     <= 10'h000;
      standstill     <= 1'b0;
      coilCurrent    <= RUN_RESET;
      microStepPulse <= 1'b0;
      ipState        <= IP_IDLE;
      ipLeft         <= 9'h000;
      ipTimer        <= 21'h000000;
      ipPeriod       <= 21'h000001;
      ipDir          <= 1'b0;
    end else begin
      stepPrev       <= next_stepPrev;
      fastStill      <= next_fastStill;
      resolution     <= next_resolution;
      intpolEn       <= intpolNext;
      dedge          <= dedgeNext;
      holdCurrent    <= next_holdCurrent;
      runCurrent     <= next_runCurrent;
      regRdata       <= next_regRdata;
      microCount     <= next_microCount;
      standstill     <= next_standstill;
      coilCurrent    <= next_coilCurrent;
      microStepPulse <= next_microStepPulse;
      ipState        <= next_ipState;
      ipLeft         <= next_ipLeft;
      ipTimer        <= next_ipTimer;
      ipPeriod       <= next_ipPeriod;
      ipDir          <= next_ipDir;
    end
  end
endmodule

// *** verification/step_seq_monitor.sv ***
/*
  Port checker for the step sequencer top module.
  Assumes one clock and a synchronous active high reset.
*/
module step_seq_monitor
  import step_seq_pkg::*;
#(
  parameter int FAST_CYCLES = FAST_STILL_COUNT
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        stepPin,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic [9:0]  microCount,
  input wire logic        standstill,
  input wire logic [4:0]  coilCurrent,
  input wire logic        microStepPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0]  res;    // Shadow resolution code
  logic        intpol; // Shadow interpolation enable
  logic [4:0]  hold;   // Shadow hold current
  logic [4:0]  run;    // Shadow run current
  logic        pinQ;   // Last step pin sample
  logic [20:0] quiet;  // Cycles since a rising pin
  logic [9:0]  wid;    // Width, clamped at full step
  assign wid = 10'h001 << ((res > RES_FULL) ? RES_FULL : res);
  // Shadows follow writes; quiet saturates so it never wraps
  always_ff @(posedge core_clk) begin
    pinQ <= stepPin;
    if (rst) begin
      res    <= 4'h0;
      intpol <= 1'b0;
      hold   <= HOLD_RESET;
      run    <= RUN_RESET;
      quiet  <= 21'h0;
    end else begin
      if (stepPin && !pinQ)
        quiet <= 21'h0;
      else if (quiet != 21'h1FFFFF)
        quiet <= quiet + 21'h1;
      if (regWrite && regAddr == ADDR_CHOP_CFG) begin
        res    <= regWdata[CHOP_RES_POS +: 4];
        intpol <= regWdata[CHOP_INTPOL_POS];
      end
      if (regWrite && regAddr == ADDR_COIL_CUR) begin
        hold <= regWdata[CUR_HOLD_POS +: 5];
        run  <= regWdata[CUR_RUN_POS +: 5];
      end
    end
  end
  // No recent write, so a snap is not taken for a step
  sequence calm_s;
    !regWrite [*3];
  endsequence
  sequence moved_s(logic [9:0] d);
    (microCount - $past(microCount) == d) ||
    ($past(microCount) - microCount == d);
  endsequence
  stepWidth_a: assert property (
    calm_s ##0 (microStepPulse && !intpol) |-> moved_s(wid))
    else $error("step width wrong");
  interpOne_a: assert property (
    calm_s ##0 (microStepPulse && intpol) |-> moved_s(10'h001))
    else $error("microstep not one");
  fullGrid_a: assert property (
    calm_s ##0 (microStepPulse && !intpol && wid == 10'h100)
    |-> microCount[7:0] == 8'h80)
    else $error("full step off grid");
  pulseMove_a: assert property (
    calm_s |-> microStepPulse == $changed(microCount))
    else $error("pulse and move disagree");
  stillLate_a: assert property (
    $rose(standstill) |-> quiet >= 21'(FAST_CYCLES))
    else $error("standstill too early");
  stillClear_a: assert property (
    $fell(standstill) |-> microStepPulse)
    else $error("standstill cleared without step");
  holdCur_a: assert property (
    (standstill && !regWrite) [*3] |-> coilCurrent == hold)
    else $error("hold current missing");
  runCur_a: assert property (
    (!standstill && !regWrite) [*3] |-> coilCurrent == run)
    else $error("run current missing");
  statusRead_a: assert property (
    regRead && regAddr == ADDR_STATUS |=>
    regRdata[STAT_STILL_POS] == $past(standstill) &&
    regRdata[STAT_CNT_POS +: 10] == $past(microCount))
    else $error("status read wrong");
endmodule

// *** verification/step_source.sv ***
/*
  External controller model making step and direction pins.
  Assumes callers space edges by the full-step rate limit.
*/
module step_source (
  input  wire logic core_clk,
  output logic      stepPin,
  output logic      dirPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle low until the first edge
  initial begin
    stepPin = 1'b0;
    dirPin  = 1'b0;
  end
  // Direction settles before the edge; equal gaps keep even duty
  task automatic toggle(input logic d, input int gap);
    dirPin <= d;
    repeat (3) @(posedge core_clk);
    stepPin <= ~stepPin;
    repeat ((gap < 2) ? 2 : gap) @(posedge core_clk);
  endtask
endmodule

// *** verification/tb.sv ***
/*
  Self-checking bench for the step sequencer.
  Assumes the partner model and the checker compile first.
*/
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb
  import step_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STILL = 64; // Short timeouts keep the run brief
  localparam int FAST  = 16;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  regAddr  = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [31:0] regRdata;
  logic [9:0]  microCount;
  logic        standstill;
  logic [4:0]  coilCurrent;
  logic        microStepPulse;
  logic        stepPin;
  logic        dirPin;
  logic [9:0]  pos;    // Expected counter
  logic [3:0]  curRes; // Resolution code in force
  logic [4:0]  hold;
  logic [4:0]  run;
  logic        dir;
  int          fail_count = 0;
  int          checked = 0;
  int          pulses = 0; // Microstep pulses seen
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (microStepPulse === 1'b1) pulses++;
  step_dir_microstep_sequencer #(.STILL_CYCLES(STILL), .FAST_CYCLES(FAST))
  dut (
    .core_clk(core_clk), .rst(rst), .stepPin(stepPin), .dirPin(dirPin),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .microCount(microCount),
    .standstill(standstill), .coilCurrent(coilCurrent),
    .microStepPulse(microStepPulse)
  );
  step_source src (.core_clk(core_clk), .stepPin(stepPin), .dirPin(dirPin));
  function automatic logic [9:0] wd(input logic [3:0] r);
    return 10'h001 << ((r > 4'h8) ? 4'h8 : r);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // Coarser codes move the expected counter onto the new grid
  task automatic setRes(input logic [3:0] r, input logic ip, input logic de);
    wr(ADDR_CHOP_CFG, {26'h0, de, ip, r});
    if (wd(r) > wd(curRes))
      pos = (pos & ~(wd(r) - 10'h001)) | (wd(r) >> 1);
    curRes = r;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // Rise then fall; wide widths get slow steps
  task automatic period(input logic d, input int gap);
    int g;
    g = (gap > int'(wd(curRes))) ? gap : int'(wd(curRes));
    src.toggle(d, g);
    pos = d ? pos - wd(curRes) : pos + wd(curRes);
    src.toggle(d, g);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    int          base;
    int          ips[2];
    ips = '{1, 4};
    void'($urandom(32'h29C2660D));
    pos = 10'h000;
    curRes = 4'h0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(microCount, 10'h000)
    `CHK(coilCurrent, RUN_RESET)
    rd(ADDR_COIL_CUR, d);
    `CHK(d, 32'h00001F08)
    rd(4'hA, d);
    `CHK(d, 32'h00000000)
    // Codes 0 to 8 and 15, coarser each pass up to 8, random directions
    for (int r = 0; r < 10; r++) begin
      setRes((r == 9) ? 4'hF : 4'(r), 1'b0, 1'b0);
      `CHK(microCount, pos)
      repeat (4) begin
        period(1'($urandom), 6);
        `CHK(microCount, pos)
      end
    end
    // Both edges count in double-edge mode
    setRes(4'h8, 1'b0, 1'b1);
    repeat (2) begin
      dir = 1'($urandom);
      src.toggle(dir, 512);
      pos = dir ? pos - 10'h100 : pos + 10'h100;
      #1;
      `CHK(microCount, pos)
    end
    // Interpolated bursts after a measured interval
    for (int i = 0; i < 2; i++) begin
      dir = 1'($urandom);
      setRes(4'h0, 1'b1, 1'b0);
      repeat (2) period(dir, 20);
      setRes(4'(ips[i]), 1'b1, 1'b0);
      base = pulses;
      period(dir, 20);
      repeat (8) @(posedge core_clk);
      `CHK(microCount, pos)
      `CHK(10'(pulses - base), wd(curRes))
    end
    // Standstill, currents, timer restart, fast timeout
    hold = 5'($urandom);
    run  = 5'($urandom);
    wr(ADDR_COIL_CUR, {19'h0, run, 3'h0, hold});
    setRes(4'h4, 1'b0, 1'b0);
    repeat (STILL) @(posedge core_clk);
    #1;
    `CHK(coilCurrent, hold)
    period(1'b0, 6);
    `CHK(standstill, 1'b0)
    `CHK(coilCurrent, run)
    repeat (20) @(posedge core_clk);
    period(1'b1, 6);
    repeat (20) @(posedge core_clk);
    #1;
    `CHK(standstill, 1'b0)
    repeat (20) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    `CHK(d[16], 1'b1)
    wr(ADDR_GLOBAL_CFG, 32'h00000001);
    setRes(4'h0, 1'b0, 1'b0);
    period(1'b0, 6);
    `CHK(standstill, 1'b0)
    repeat (10) @(posedge core_clk);
    #1;
    `CHK(standstill, 1'b1)
    `CHK(microCount, pos)
    give_verdict();
  end
endmodule
bind step_dir_microstep_sequencer step_seq_monitor #(
  .FAST_CYCLES(FAST_CYCLES)
) u_mon (
  .core_clk(core_clk), .rst(rst), .stepPin(stepPin),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .microCount(microCount),
  .standstill(standstill), .coilCurrent(coilCurrent),
  .microStepPulse(microStepPulse)
);
